// File: logic/obt_regs.svh
// obt_regs.svh: reset values and widths for the octal registered transceiver
// assumes: included by its bare name from the package and the core module
`ifndef OBT_REGS_SVH
`define OBT_REGS_SVH

// data width of each bus and each storage register
`define OBT_DATA_W      8

// reset value of every capture clock and bus synchroniser stage
`define OBT_SYNC_RST    1'b0

// reset value of the output data flops
`define OBT_OUT_RST     8'h00

// reset value of the control group: enable inactive (high), rest low
`define OBT_CTL_RST     4'h8

// reset value of the captured-once flags
`define OBT_VLD_RST     1'b0

`endif

// File: logic/obt_pkg.sv
// obt_pkg.sv: types shared by the octal registered transceiver
// assumes: obt_regs.svh is on the include path
`include "obt_regs.svh"

package obt_pkg;

    // ========================================================================
    // control pins, grouped
    // ========================================================================
    typedef struct packed {
        logic oe_b;      // output enable, active low
        logic dir;       // high: drive b side, low: drive a side
        logic sel_a2b;   // high: stored a register, low: live a bus
        logic sel_b2a;   // high: stored b register, low: live b bus
    } obt_ctl_t;

    // ========================================================================
    // which bus the device drives
    // ========================================================================
    typedef enum logic [2:0] {
        OBT_DRV_NONE = 3'b001,
        OBT_DRV_A    = 3'b010,
        OBT_DRV_B    = 3'b100
    } obt_drv_t;

endpackage

// File: logic/obt_transceiver.sv
// obt_transceiver.sv: octal bus transceiver with a and b storage registers
// assumes: every pin input is asynchronous to i_sys_clk; the bus pads
// resolve each two-way pin from its output and output enable
//
// What this block does
// - two eight-bit registers, one per bus side
// - capture clock rises, load that side's bus
// - capture ignores enable and direction settings
// - enable low: direction picks the driven bus
// - direction low, select low: live b to a
// - direction low, select high: b register to a
// - direction high, select low: live a to b
// - direction high, select high: a register to b
// - build option inverts every driven bit
// - enable high, no clock edge: drive nothing, registers hold
// - enable high, both clocks: store both
// - only a clock rises: store a
// - only b clock rises: store b
// - undriven input bus may load either register
// - never drive both buses at once
`timescale 1ns/10ps
`include "obt_regs.svh"

module obt_transceiver #(
    parameter int unsigned DATA_W = `OBT_DATA_W,
    parameter bit          INVERT = 1'b0
) (
    input  wire logic              i_sys_clk,
    input  wire logic              i_rst_b,
    input  wire logic              i_oe_b,
    input  wire logic              i_dir,
    input  wire logic              i_a_to_b_source_select,
    input  wire logic              i_b_to_a_source_select,
    input  wire logic              i_a_side_capture_clock,
    input  wire logic              i_b_side_capture_clock,
    input  wire logic [DATA_W-1:0] i_a_side_bus,
    output logic      [DATA_W-1:0] o_a_side_bus,
    output logic                   o_a_side_bus_oe,
    input  wire logic [DATA_W-1:0] i_b_side_bus,
    output logic      [DATA_W-1:0] o_b_side_bus,
    output logic                   o_b_side_bus_oe,
    output logic      [DATA_W-1:0] o_a_reg,
    output logic      [DATA_W-1:0] o_b_reg,
    output logic                   o_a_reg_valid,
    output logic                   o_b_reg_valid,
    output logic                   o_a_capture,
    output logic                   o_b_capture
);

    // ========================================================================
    // declarations
    // ========================================================================
    obt_pkg::obt_ctl_t   ctl_pin;
    obt_pkg::obt_ctl_t   ctl_s1_ff;
    obt_pkg::obt_ctl_t   ctl_s2_ff;
    obt_pkg::obt_ctl_t   nxt_ctl_s1;
    obt_pkg::obt_ctl_t   nxt_ctl_s2;

    logic [2:0]          a_clk_sync_ff;
    logic [2:0]          b_clk_sync_ff;
    logic [2:0]          nxt_a_clk_sync;
    logic [2:0]          nxt_b_clk_sync;

    logic [DATA_W-1:0]   a_s1_ff;
    logic [DATA_W-1:0]   a_s2_ff;
    logic [DATA_W-1:0]   a_s3_ff;
    logic [DATA_W-1:0]   b_s1_ff;
    logic [DATA_W-1:0]   b_s2_ff;
    logic [DATA_W-1:0]   b_s3_ff;
    logic [DATA_W-1:0]   nxt_a_s1;
    logic [DATA_W-1:0]   nxt_a_s2;
    logic [DATA_W-1:0]   nxt_a_s3;
    logic [DATA_W-1:0]   nxt_b_s1;
    logic [DATA_W-1:0]   nxt_b_s2;
    logic [DATA_W-1:0]   nxt_b_s3;

    logic                a_clk_rise;
    logic                b_clk_rise;

    logic [DATA_W-1:0]   a_reg_ff;
    logic [DATA_W-1:0]   b_reg_ff;
    logic [DATA_W-1:0]   nxt_a_reg;
    logic [DATA_W-1:0]   nxt_b_reg;
    logic                a_vld_ff;
    logic                b_vld_ff;
    logic                nxt_a_vld;
    logic                nxt_b_vld;
    logic                a_cap_ff;
    logic                b_cap_ff;

    obt_pkg::obt_drv_t   drv_ff;
    obt_pkg::obt_drv_t   nxt_drv;
    obt_pkg::obt_drv_t   want_drv;

    logic [DATA_W-1:0]   a_out_ff;
    logic [DATA_W-1:0]   b_out_ff;
    logic [DATA_W-1:0]   nxt_a_out;
    logic [DATA_W-1:0]   nxt_b_out;
    logic [DATA_W-1:0]   src_to_a;
    logic [DATA_W-1:0]   src_to_b;
    logic [DATA_W-1:0]   pol_to_a;
    logic [DATA_W-1:0]   pol_to_b;

    // ========================================================================
    // functions
    // ========================================================================
    // rising edge seen between the second and third synchroniser stages
    function automatic logic edge_up(input logic [2:0] sync);
        edge_up = sync[1] & ~sync[2];
    endfunction

    // two-way choice between live bus data and stored data
    function automatic logic [DATA_W-1:0] pick_src(
        input logic              stored,
        input logic [DATA_W-1:0] live,
        input logic [DATA_W-1:0] held
    );
        pick_src = stored ? held : live;
    endfunction

    // ========================================================================
    // control pin synchronisers
    // ========================================================================
    // pins gathered into the control group
    always_comb begin
        ctl_pin.oe_b    = i_oe_b;
        ctl_pin.dir     = i_dir;
        ctl_pin.sel_a2b = i_a_to_b_source_select;
        ctl_pin.sel_b2a = i_b_to_a_source_select;
    end

    // two stages; only the second stage feeds any logic
    always_comb begin
        nxt_ctl_s1 = ctl_pin;
        nxt_ctl_s2 = ctl_s1_ff;
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctl_s1_ff <= `OBT_CTL_RST;
            ctl_s2_ff <= `OBT_CTL_RST;
        end else begin
            ctl_s1_ff <= nxt_ctl_s1;
            ctl_s2_ff <= nxt_ctl_s2;
        end
    end

    // ========================================================================
    // capture clock and bus synchronisers
    // ========================================================================
    // clocks get a third stage for edge detection; bus data also runs three stages,
    // one past the edge tap, so the value used is the one present before the edge
    always_comb begin
        nxt_a_clk_sync = {a_clk_sync_ff[1:0], i_a_side_capture_clock};
        nxt_b_clk_sync = {b_clk_sync_ff[1:0], i_b_side_capture_clock};
        nxt_a_s1 = i_a_side_bus;
        nxt_a_s2 = a_s1_ff;
        nxt_a_s3 = a_s2_ff;
        nxt_b_s1 = i_b_side_bus;
        nxt_b_s2 = b_s1_ff;
        nxt_b_s3 = b_s2_ff;
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            a_clk_sync_ff <= {3{`OBT_SYNC_RST}};
            b_clk_sync_ff <= {3{`OBT_SYNC_RST}};
            a_s1_ff <= {DATA_W{`OBT_SYNC_RST}};
            a_s2_ff <= {DATA_W{`OBT_SYNC_RST}};
            a_s3_ff <= {DATA_W{`OBT_SYNC_RST}};
            b_s1_ff <= {DATA_W{`OBT_SYNC_RST}};
            b_s2_ff <= {DATA_W{`OBT_SYNC_RST}};
            b_s3_ff <= {DATA_W{`OBT_SYNC_RST}};
        end else begin
            a_clk_sync_ff <= nxt_a_clk_sync;
            b_clk_sync_ff <= nxt_b_clk_sync;
            a_s1_ff <= nxt_a_s1;
            a_s2_ff <= nxt_a_s2;
            a_s3_ff <= nxt_a_s3;
            b_s1_ff <= nxt_b_s1;
            b_s2_ff <= nxt_b_s2;
            b_s3_ff <= nxt_b_s3;
        end
    end

    // edge strobes, independent of enable and direction
    assign a_clk_rise = edge_up(a_clk_sync_ff);
    assign b_clk_rise = edge_up(b_clk_sync_ff);

    // ========================================================================
    // storage registers
    // ========================================================================
    // each register loads only from its own bus on its own clock edge;
    // the clocks are independent, so one, the other or both may load in
    // a cycle, and the undriven bus is as good a source as any
    always_comb begin
        nxt_a_reg = a_reg_ff;
        nxt_b_reg = b_reg_ff;
        if (a_clk_rise) begin
            nxt_a_reg = a_s3_ff;
        end
        if (b_clk_rise) begin
            nxt_b_reg = b_s3_ff;
        end
        nxt_a_vld = a_vld_ff | a_clk_rise;
        nxt_b_vld = b_vld_ff | b_clk_rise;
    end

    // no reset on the storage itself, as in the part it models
    always_ff @(posedge i_sys_clk) begin
        a_reg_ff <= nxt_a_reg;
        b_reg_ff <= nxt_b_reg;
    end

    // flags that tell the user a register has been loaded at least once
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            a_vld_ff <= `OBT_VLD_RST;
            b_vld_ff <= `OBT_VLD_RST;
            a_cap_ff <= `OBT_VLD_RST;
            b_cap_ff <= `OBT_VLD_RST;
        end else begin
            a_vld_ff <= nxt_a_vld;
            b_vld_ff <= nxt_b_vld;
            a_cap_ff <= a_clk_rise;
            b_cap_ff <= b_clk_rise;
        end
    end

    // ========================================================================
    // drive direction state
    // ========================================================================
    // wanted drive from enable and direction
    always_comb begin
        if (ctl_s2_ff.oe_b) begin
            want_drv = obt_pkg::OBT_DRV_NONE;
        end else if (ctl_s2_ff.dir) begin
            want_drv = obt_pkg::OBT_DRV_B;
        end else begin
            want_drv = obt_pkg::OBT_DRV_A;
        end
    end

    // a swap between a and b passes through one idle cycle so the two
    // enables never overlap, even for a single edge
    always_comb begin
        case (drv_ff)
            obt_pkg::OBT_DRV_NONE: begin
                nxt_drv = want_drv;
            end
            obt_pkg::OBT_DRV_A: begin
                if (want_drv == obt_pkg::OBT_DRV_B) begin
                    nxt_drv = obt_pkg::OBT_DRV_NONE;
                end else begin
                    nxt_drv = want_drv;
                end
            end
            obt_pkg::OBT_DRV_B: begin
                if (want_drv == obt_pkg::OBT_DRV_A) begin
                    nxt_drv = obt_pkg::OBT_DRV_NONE;
                end else begin
                    nxt_drv = want_drv;
                end
            end
            default: begin
                nxt_drv = obt_pkg::OBT_DRV_NONE;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            drv_ff <= obt_pkg::OBT_DRV_NONE;
        end else begin
            drv_ff <= nxt_drv;
        end
    end

    // ========================================================================
    // output data path
    // ========================================================================
    // source choice per direction: live bus or stored register
    assign src_to_a = pick_src(ctl_s2_ff.sel_b2a, b_s3_ff, b_reg_ff);
    assign src_to_b = pick_src(ctl_s2_ff.sel_a2b, a_s3_ff, a_reg_ff);

    // polarity per bit, fixed at build time
    genvar gi;
    generate
        for (gi = 0; gi < DATA_W; gi++) begin : g_pol
            assign pol_to_a[gi] = src_to_a[gi] ^ INVERT;
            assign pol_to_b[gi] = src_to_b[gi] ^ INVERT;
        end
    endgenerate

    always_comb begin
        nxt_a_out = pol_to_a;
        nxt_b_out = pol_to_b;
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            a_out_ff <= `OBT_OUT_RST;
            b_out_ff <= `OBT_OUT_RST;
        end else begin
            a_out_ff <= nxt_a_out;
            b_out_ff <= nxt_b_out;
        end
    end

    // ========================================================================
    // outputs
    // ========================================================================
    // enables come straight from the one-hot state, so at most one is set
    assign o_a_side_bus_oe = (drv_ff == obt_pkg::OBT_DRV_A);
    assign o_b_side_bus_oe = (drv_ff == obt_pkg::OBT_DRV_B);
    assign o_a_side_bus    = a_out_ff;
    assign o_b_side_bus    = b_out_ff;
    assign o_a_reg         = a_reg_ff;
    assign o_b_reg         = b_reg_ff;
    assign o_a_reg_valid   = a_vld_ff;
    assign o_b_reg_valid   = b_vld_ff;
    assign o_a_capture     = a_cap_ff;
    assign o_b_capture     = b_cap_ff;

endmodule // obt_transceiver

// File: testbench/obt_bus_model.sv
// obt_bus_model.sv: far-side logic that drives one parallel bus
// assumes: the device output and enable come straight from the dut
`timescale 1ns/10ps

module obt_bus_model #(
    parameter int unsigned W = 8
) (
    input  wire logic         i_sys_clk,
    input  wire logic         i_en,
    input  wire logic [W-1:0] i_val,
    input  wire logic         i_dev_oe,
    input  wire logic [W-1:0] i_dev_val,
    output logic      [W-1:0] o_wire
);
    logic [W-1:0] last_ff;

    // remember the wire so a released bus never shows a stale value
    always_ff @(posedge i_sys_clk) begin
        last_ff <= o_wire;
    end

    // resolve the wire: device first, then this side, else a toggling pattern
    always_comb begin
        if (i_dev_oe) begin
            o_wire = i_dev_val;
        end else if (i_en) begin
            o_wire = i_val;
        end else begin
            o_wire = ~last_ff;
        end
    end
endmodule // obt_bus_model

// File: testbench/obt_transceiver_monitor.sv
// obt_transceiver_monitor.sv: port assertions for the transceiver
// assumes: bound to obt_transceiver, one clock domain
`timescale 1ns/10ps

module obt_transceiver_monitor #(
    parameter int unsigned DATA_W = 8,
    parameter bit          INVERT = 1'b0
) (
    input wire logic              i_sys_clk,
    input wire logic              i_rst_b,
    input wire logic              i_oe_b,
    input wire logic              i_dir,
    input wire logic              i_a_to_b_source_select,
    input wire logic              i_b_to_a_source_select,
    input wire logic              i_a_side_capture_clock,
    input wire logic              i_b_side_capture_clock,
    input wire logic [DATA_W-1:0] i_a_side_bus,
    input wire logic [DATA_W-1:0] i_b_side_bus,
    input wire logic [DATA_W-1:0] o_a_side_bus,
    input wire logic [DATA_W-1:0] o_b_side_bus,
    input wire logic              o_a_side_bus_oe,
    input wire logic              o_b_side_bus_oe,
    input wire logic [DATA_W-1:0] o_a_reg,
    input wire logic [DATA_W-1:0] o_b_reg,
    input wire logic              o_a_reg_valid,
    input wire logic              o_b_reg_valid,
    input wire logic              o_a_capture,
    input wire logic              o_b_capture
);
    localparam logic [DATA_W-1:0] FLIP = {DATA_W{INVERT}};

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);

    // ========================================================================
    // capture steps
    // ========================================================================
    sequence s_a_rise; $rose(i_a_side_capture_clock); endsequence
    sequence s_b_rise; $rose(i_b_side_capture_clock); endsequence
    sequence s_a_done; ##[2:6] o_a_capture; endsequence
    sequence s_b_done; ##[2:6] o_b_capture; endsequence

    property p_no_both; !(o_a_side_bus_oe && o_b_side_bus_oe); endproperty
    property p_off; i_oe_b [*8] |-> !o_a_side_bus_oe && !o_b_side_bus_oe; endproperty
    property p_drv_b; (!i_oe_b && i_dir) [*8] |-> o_b_side_bus_oe && !o_a_side_bus_oe;
    endproperty
    property p_drv_a; (!i_oe_b && !i_dir) [*8] |-> o_a_side_bus_oe && !o_b_side_bus_oe;
    endproperty
    property p_live_b; (i_dir && !i_a_to_b_source_select && $stable(i_a_side_bus)) [*8]
        |-> o_b_side_bus == (i_a_side_bus ^ FLIP); endproperty
    property p_stored_b; (i_dir && i_a_to_b_source_select && o_a_reg_valid
        && $stable(o_a_reg)) [*8] |-> o_b_side_bus == (o_a_reg ^ FLIP); endproperty
    property p_live_a; (!i_dir && !i_b_to_a_source_select && $stable(i_b_side_bus)) [*8]
        |-> o_a_side_bus == (i_b_side_bus ^ FLIP); endproperty
    property p_stored_a; (!i_dir && i_b_to_a_source_select && o_b_reg_valid
        && $stable(o_b_reg)) [*8] |-> o_a_side_bus == (o_b_reg ^ FLIP); endproperty
    property p_cap_a; s_a_rise |-> s_a_done; endproperty
    property p_cap_b; s_b_rise |-> s_b_done; endproperty

    a_no_both: assert property (p_no_both) else $error("both buses driven");
    a_off: assert property (p_off) else $error("bus driven while disabled");
    a_drv_b: assert property (p_drv_b) else $error("b side not driven");
    a_drv_a: assert property (p_drv_a) else $error("a side not driven");
    a_live_b: assert property (p_live_b) else $error("live a to b wrong");
    a_stored_b: assert property (p_stored_b) else $error("stored a to b wrong");
    a_live_a: assert property (p_live_a) else $error("live b to a wrong");
    a_stored_a: assert property (p_stored_a) else $error("stored b to a wrong");
    a_cap_a: assert property (p_cap_a) else $error("a capture missing");
    a_cap_b: assert property (p_cap_b) else $error("b capture missing");
endmodule // obt_transceiver_monitor

bind obt_transceiver obt_transceiver_monitor #(.DATA_W(DATA_W), .INVERT(INVERT)) u_mon (
    .i_sys_clk, .i_rst_b, .i_oe_b, .i_dir, .i_a_to_b_source_select,
    .i_b_to_a_source_select, .i_a_side_capture_clock, .i_b_side_capture_clock,
    .i_a_side_bus, .i_b_side_bus, .o_a_side_bus, .o_b_side_bus, .o_a_side_bus_oe,
    .o_b_side_bus_oe, .o_a_reg, .o_b_reg, .o_a_reg_valid, .o_b_reg_valid,
    .o_a_capture, .o_b_capture);

// File: testbench/octal_registered_bus_transceiver_tb_top.sv
// octal_registered_bus_transceiver_tb_top.sv: self-checking bench
// assumes: obt_pkg, obt_transceiver, bus models and monitor are compiled first
`timescale 1ns/10ps

module octal_registered_bus_transceiver_tb_top;
    localparam bit INV = 1'b1;
    logic             i_sys_clk, i_rst_b, a_cap, b_cap, a_en, b_en;
    obt_pkg::obt_ctl_t ctl;
    logic [7:0]       a_val, b_val, a_bus, b_bus, a_out, b_out, a_reg, b_reg;
    logic [7:0]       a_out_t, b_out_t;
    logic             a_oe, b_oe, a_vld, b_vld;
    int               errors, cmp_count, cycles;

    // ========================================================================
    // dut and far-side bus models
    // ========================================================================
    obt_transceiver #(.DATA_W(8), .INVERT(INV)) DUT (.i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b), .i_oe_b(ctl.oe_b), .i_dir(ctl.dir),
        .i_a_to_b_source_select(ctl.sel_a2b), .i_b_to_a_source_select(ctl.sel_b2a),
        .i_a_side_capture_clock(a_cap), .i_b_side_capture_clock(b_cap),
        .i_a_side_bus(a_bus), .o_a_side_bus(a_out), .o_a_side_bus_oe(a_oe),
        .i_b_side_bus(b_bus), .o_b_side_bus(b_out), .o_b_side_bus_oe(b_oe),
        .o_a_reg(a_reg), .o_b_reg(b_reg), .o_a_reg_valid(a_vld), .o_b_reg_valid(b_vld),
        .o_a_capture(), .o_b_capture());
    // true-polarity build on the same buses; it only listens, never drives
    obt_transceiver #(.DATA_W(8), .INVERT(1'b0)) dut_true (.i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b), .i_oe_b(ctl.oe_b), .i_dir(ctl.dir),
        .i_a_to_b_source_select(ctl.sel_a2b), .i_b_to_a_source_select(ctl.sel_b2a),
        .i_a_side_capture_clock(a_cap), .i_b_side_capture_clock(b_cap),
        .i_a_side_bus(a_bus), .o_a_side_bus(a_out_t), .o_a_side_bus_oe(),
        .i_b_side_bus(b_bus), .o_b_side_bus(b_out_t), .o_b_side_bus_oe(),
        .o_a_reg(), .o_b_reg(), .o_a_reg_valid(), .o_b_reg_valid(),
        .o_a_capture(), .o_b_capture());
    obt_bus_model #(.W(8)) u_a (.i_sys_clk(i_sys_clk), .i_en(a_en), .i_val(a_val),
        .i_dev_oe(a_oe), .i_dev_val(a_out), .o_wire(a_bus));
    obt_bus_model #(.W(8)) u_b (.i_sys_clk(i_sys_clk), .i_en(b_en), .i_val(b_val),
        .i_dev_oe(b_oe), .i_dev_val(b_out), .o_wire(b_bus));

    // ========================================================================
    // tasks
    // ========================================================================
    function automatic logic [7:0] f(input logic [7:0] x);
        return x ^ {8{INV}};
    endfunction
    task automatic end_sim();
        if (errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic settle();
        repeat (10) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
    endtask
    task automatic set_ctl(input logic oe_b, dir, a_to_b_source_select, b_to_a_source_select);
        @(posedge i_sys_clk);
        ctl <= '{oe_b, dir, a_to_b_source_select, b_to_a_source_select};
        a_en <= oe_b | dir;
        b_en <= oe_b | ~dir;
        settle();
    endtask
    task automatic drive(input logic [7:0] a, b);
        @(posedge i_sys_clk);
        a_val <= a;
        b_val <= b;
        settle();
    endtask
    task automatic capture(input logic ca, cb);
        @(posedge i_sys_clk);
        a_cap <= ca;
        b_cap <= cb;
        repeat (4) @(posedge i_sys_clk);
        a_cap <= 1'b0;
        b_cap <= 1'b0;
        settle();
    endtask

    // clock and hang guard
    initial begin
        i_sys_clk = 1'b0;
        forever #2 i_sys_clk = ~i_sys_clk;
    end
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            end_sim();
        end
    end

    // main sequence
    initial begin
        errors = 0; cmp_count = 0; cycles = 0; i_rst_b = 1'b0;
        ctl = '{1'b1, 1'b0, 1'b0, 1'b0};
        a_cap = 1'b0; b_cap = 1'b0; a_en = 1'b1; b_en = 1'b1; a_val = '0; b_val = '0;
        repeat (20) @(posedge i_sys_clk);
        i_rst_b <= 1'b1;
        drive(8'h3c, 8'hc5);
        check({6'h0, a_oe, b_oe}, 8'h00);
        capture(1'b1, 1'b1);
        check(a_reg, 8'h3c);
        check(b_reg, 8'hc5);
        check({6'h0, a_vld, b_vld}, 8'h03);
        drive(8'h99, 8'h66);
        check(a_reg, 8'h3c);
        check(b_reg, 8'hc5);
        capture(1'b1, 1'b0);
        check(a_reg, 8'h99);
        check(b_reg, 8'hc5);
        set_ctl(1'b0, 1'b1, 1'b0, 1'b0);
        check({6'h0, a_oe, b_oe}, 8'h01);
        check(b_out, f(8'h99));
        check(b_out_t, 8'h99);
        check(b_bus, f(8'h99));
        drive(8'h81, 8'h00);
        check(b_out, f(8'h81));
        capture(1'b1, 1'b0);
        check(a_reg, 8'h81);
        capture(1'b0, 1'b1);
        check(b_reg, f(8'h81));
        set_ctl(1'b0, 1'b1, 1'b1, 1'b0);
        drive(8'h42, 8'h00);
        check(b_out, f(8'h81));
        check(b_out_t, 8'h81);
        set_ctl(1'b0, 1'b0, 1'b0, 1'b0);
        check({6'h0, a_oe, b_oe}, 8'h02);
        drive(8'h42, 8'h17);
        check(a_out, f(8'h17));
        check(a_out_t, 8'h17);
        capture(1'b0, 1'b1);
        check(b_reg, 8'h17);
        set_ctl(1'b0, 1'b0, 1'b0, 1'b1);
        drive(8'h42, 8'h2e);
        check(a_out, f(8'h17));
        check(a_out_t, 8'h17);
        set_ctl(1'b1, 1'b0, 1'b0, 1'b1);
        check({6'h0, a_oe, b_oe}, 8'h00);
        end_sim();
    end
endmodule // octal_registered_bus_transceiver_tb_top
